// >>> core/frt_pkg.sv
// Register map, field positions and constants of the free-running timer
package frt_pkg;

  // Register indices (byte offsets on the device bus); APB address = 4 * index
  localparam logic [7:0] IDX_TIMER_CONTROL   = 8'h12;
  localparam logic [7:0] IDX_TIMER_STATUS    = 8'h13;
  localparam logic [7:0] IDX_CAPTURE_HIGH    = 8'h14;
  localparam logic [7:0] IDX_CAPTURE_LOW     = 8'h15;
  localparam logic [7:0] IDX_ALT_COUNT_HIGH  = 8'h1A;
  localparam logic [7:0] IDX_ALT_COUNT_LOW   = 8'h1B;
  localparam logic [7:0] IDX_COUNT_HIGH      = 8'h18;
  localparam logic [7:0] IDX_COUNT_LOW       = 8'h19;
  localparam logic [7:0] IDX_ANALOG_CONTROL  = 8'h1D;
  localparam int         ADDR_LSB            = 2;

  // timer_control fields
  localparam int CTL_CAPTURE_IRQ_EN   = 7;
  localparam int CTL_OVERFLOW_IRQ_EN  = 5;
  localparam int CTL_EDGE_SELECT      = 1;
  // timer_status fields
  localparam int STS_CAPTURE_FLAG     = 7;
  localparam int STS_OVERFLOW_FLAG    = 5;
  // analog_control field
  localparam int ACTL_SOURCE_SELECT   = 0;

  localparam logic [15:0] COUNT_RESET   = 16'hFFFC;
  localparam logic [15:0] COUNT_ALL_ONE = 16'hFFFF;
  localparam logic [1:0]  PRESCALE_LAST = 2'h3;

  // Oscillator startup delay before counting begins
  localparam int STARTUP_CYCLES = 4064;

endpackage : frt_pkg

// >>> core/free_running_timer_capture.sv
// Free-running 16-bit timer with latched count views and input capture, APB slave
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Counter advances once per four bus clocks via fixed prescaler.
// - Reset loads FFFC; counting begins after startup delay.
// - Count high/low bytes are read-only; writes ignored.
// - High-byte read freezes low byte until low byte read; no refreeze.
// - Overflow flag sets when counter wraps FFFF to 0000.
// - Timer irq while overflow flag and overflow enable both set.
// - Overflow flag clears only on count-low read after status read.
// - Count reads never disturb counter sequence.
// - Alternate view: read-only, no effect on flag, irq or counter.
// - Alternate view has own low-byte latch, frozen by its high read.
// - Capture source is pin or comparator-2 flag, by select bit.
// - Active edge on source copies counter into capture pair.
// - Edge-select bit chooses triggering transition.
// - Reset leaves capture pair unchanged.
// - Captured value equals preceding count plus one.
// - Capture high read blocks captures until capture low read.
// - Capture flag clears on capture-low read after status read.
// - Capture pair always holds most recent capture value.
// - Edge select one is rising, zero falling; reset keeps it.
// - Capture flag sets on selected edge; reset keeps it.
// - Capture irq only while capture enable set; reset clears enable.
module free_running_timer_capture
  import frt_pkg::*;
#(
  parameter int STARTUP_DELAY = STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Capture sources
  input  wire logic        capture_pin,
  input  wire logic        comparator_two_flag,
  // Interrupt request
  output logic             timer_irq
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic [9:0] idx;
  logic       acc;
  logic       rd;
  logic       wr;
  logic       hit_ctl;
  logic       hit_sts;
  logic       hit_cnth;
  logic       hit_cntl;
  logic       hit_alth;
  logic       hit_altl;
  logic       hit_caph;
  logic       hit_capl;
  logic       hit_actl;
  logic       mapped;

  assign idx      = paddr[11:ADDR_LSB];
  assign acc      = psel & penable & ~pready;
  assign rd       = acc & ~pwrite;
  assign wr       = acc & pwrite & pstrb[0];
  assign hit_ctl  = (idx == {2'h0, IDX_TIMER_CONTROL});
  assign hit_sts  = (idx == {2'h0, IDX_TIMER_STATUS});
  assign hit_cnth = (idx == {2'h0, IDX_COUNT_HIGH});
  assign hit_cntl = (idx == {2'h0, IDX_COUNT_LOW});
  assign hit_alth = (idx == {2'h0, IDX_ALT_COUNT_HIGH});
  assign hit_altl = (idx == {2'h0, IDX_ALT_COUNT_LOW});
  assign hit_caph = (idx == {2'h0, IDX_CAPTURE_HIGH});
  assign hit_capl = (idx == {2'h0, IDX_CAPTURE_LOW});
  assign hit_actl = (idx == {2'h0, IDX_ANALOG_CONTROL});
  assign mapped   = hit_ctl | hit_sts | hit_cnth | hit_cntl | hit_alth
                  | hit_altl | hit_caph | hit_capl | hit_actl;

  // ----------------------------------------------------------------------
  // Startup delay and prescaler
  // ----------------------------------------------------------------------
  logic [12:0] start_q;
  logic        running;
  logic [1:0]  pre_q;
  logic        tick;

  assign running = (start_q == 13'(STARTUP_DELAY));
  assign tick    = running & (pre_q == PRESCALE_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= '0;
    end else if (!running) begin
      start_q <= start_q + 13'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (running) begin
      pre_q <= pre_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Free-running counter
  // ----------------------------------------------------------------------
  logic [15:0] count_q;
  logic        wrap;

  assign wrap = tick & (count_q == COUNT_ALL_ONE);

  // Bus reads never touch this register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= COUNT_RESET;
    end else if (tick) begin
      count_q <= count_q + 16'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Low-byte latches for both count views
  // ----------------------------------------------------------------------
  logic       frz_q;
  logic [7:0] frz_byte_q;
  logic       afrz_q;
  logic [7:0] afrz_byte_q;
  logic [7:0] cnt_low;
  logic [7:0] alt_low;

  assign cnt_low = frz_q  ? frz_byte_q  : count_q[7:0];
  assign alt_low = afrz_q ? afrz_byte_q : count_q[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz_q  <= 1'b0;
      afrz_q <= 1'b0;
    end else begin
      if (rd && hit_cntl) begin
        frz_q <= 1'b0;
      end else if (rd && hit_cnth) begin
        frz_q <= 1'b1;
      end
      if (rd && hit_altl) begin
        afrz_q <= 1'b0;
      end else if (rd && hit_alth) begin
        afrz_q <= 1'b1;
      end
    end
  end

  // Only the first high read loads the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz_byte_q  <= '0;
      afrz_byte_q <= '0;
    end else begin
      if (rd && hit_cnth && !frz_q) begin
        frz_byte_q <= count_q[7:0];
      end
      if (rd && hit_alth && !afrz_q) begin
        afrz_byte_q <= count_q[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic ovf_ie_q;
  logic cap_ie_q;
  logic edge_q;
  logic src_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ie_q <= 1'b0;
      cap_ie_q <= 1'b0;
      src_q    <= 1'b0;
    end else begin
      if (wr && hit_ctl) begin
        ovf_ie_q <= pwdata[CTL_OVERFLOW_IRQ_EN];
        cap_ie_q <= pwdata[CTL_CAPTURE_IRQ_EN];
      end
      if (wr && hit_actl) begin
        src_q <= pwdata[ACTL_SOURCE_SELECT];
      end
    end
  end

  // No reset: edge select survives reset
  always_ff @(posedge pclk) begin
    if (wr && hit_ctl) begin
      edge_q <= pwdata[CTL_EDGE_SELECT];
    end
  end

  // ----------------------------------------------------------------------
  // Capture source synchroniser and edge detect
  // ----------------------------------------------------------------------
  logic [1:0] pin_sync_q;
  logic [1:0] cmp_sync_q;
  logic       src_prev_q;
  logic       src_now;
  logic       edge_hit;
  logic       cap_block_q;
  logic       cap_event;
  logic [1:0] prime_q;
  logic       sync_ok;

  assign src_now  = src_q ? cmp_sync_q[1] : pin_sync_q[1];
  assign edge_hit = edge_q ? (src_now & ~src_prev_q)
                           : (~src_now & src_prev_q);
  assign sync_ok   = &prime_q;
  assign cap_event = edge_hit & sync_ok & ~cap_block_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_q <= '0;
      cmp_sync_q <= '0;
      src_prev_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], capture_pin};
      cmp_sync_q <= {cmp_sync_q[0], comparator_two_flag};
      src_prev_q <= src_now;
    end
  end

  // Edges wait until pipe and previous sample hold real levels:
  // a line idling high after reset, or a source switch, never fakes a capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prime_q <= '0;
    end else if (wr && hit_actl) begin
      prime_q <= '0;
    end else if (!sync_ok) begin
      prime_q <= prime_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Count history matching the synchroniser depth
  // ----------------------------------------------------------------------
  logic [15:0] hist1_q;
  logic [15:0] hist2_q;

  // One stage per sync flop: at detection hist2_q is the count that stood
  // while the line moved, so a tick inside the sync delay is not counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist1_q <= COUNT_RESET;
      hist2_q <= COUNT_RESET;
    end else begin
      hist1_q <= count_q;
      hist2_q <= hist1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Capture pair; no reset so contents survive it
  // ----------------------------------------------------------------------
  logic [15:0] cap_q;

  // Stored value is one past the count that preceded the transition
  always_ff @(posedge pclk) begin
    if (cap_event) begin
      cap_q <= hist2_q + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_block_q <= 1'b0;
    end else if (rd && hit_capl) begin
      cap_block_q <= 1'b0;
    end else if (rd && hit_caph) begin
      cap_block_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags; no reset, arm on status read
  // ----------------------------------------------------------------------
  logic ovf_q;
  logic capf_q;
  logic ovf_arm_q;
  logic cap_arm_q;
  logic ovf_clr;
  logic cap_clr;

  assign ovf_clr = rd & hit_cntl & ovf_arm_q;
  assign cap_clr = rd & hit_capl & cap_arm_q;

  // Set beats clear in the same cycle
  always_ff @(posedge pclk) begin
    ovf_q  <= wrap | (ovf_q & ~ovf_clr);
    capf_q <= cap_event | (capf_q & ~cap_clr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_arm_q <= 1'b0;
      cap_arm_q <= 1'b0;
    end else if (rd && hit_sts) begin
      ovf_arm_q <= ovf_q;
      cap_arm_q <= capf_q;
    end else begin
      if (ovf_clr) begin
        ovf_arm_q <= 1'b0;
      end
      if (cap_clr) begin
        cap_arm_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and APB answer
  // ----------------------------------------------------------------------
  logic [7:0] ctl_rd;
  logic [7:0] sts_rd;
  logic [7:0] rd_byte;

  always_comb begin
    ctl_rd = '0;
    ctl_rd[CTL_OVERFLOW_IRQ_EN] = ovf_ie_q;
    ctl_rd[CTL_CAPTURE_IRQ_EN]  = cap_ie_q;
    ctl_rd[CTL_EDGE_SELECT]     = edge_q;
    sts_rd = '0;
    sts_rd[STS_OVERFLOW_FLAG]   = ovf_q;
    sts_rd[STS_CAPTURE_FLAG]    = capf_q;
  end

  // Count, alt and capture bytes have no write path
  assign rd_byte = hit_ctl  ? ctl_rd
                 : hit_sts  ? sts_rd
                 : hit_cnth ? count_q[15:8]
                 : hit_cntl ? cnt_low
                 : hit_alth ? count_q[15:8]
                 : hit_altl ? alt_low
                 : hit_caph ? cap_q[15:8]
                 : hit_capl ? cap_q[7:0]
                 : hit_actl ? {7'h0, src_q}
                 : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= '0;
      timer_irq <= 1'b0;
    end else begin
      pready    <= acc;
      pslverr   <= acc & ~mapped;
      prdata    <= rd ? {24'h0, rd_byte} : 32'h0;
      timer_irq <= (ovf_q & ovf_ie_q) | (capf_q & cap_ie_q);
    end
  end

endmodule : free_running_timer_capture
`default_nettype wire

// >>> sim/frt_monitor.sv
// Port checker for the free-running timer block
`timescale 1ns/1ps
`default_nettype none
module frt_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt
  input wire logic        timer_irq
);
  // ------------------------------
  // Helpers
  // ------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [7:0] ix = paddr[9:2];
  wire logic mapped = paddr[11:10] == 2'h0 && ix inside {[8'h12:8'h15], [8'h18:8'h1B], 8'h1D};
  // Only a control write or a count-low or capture-low read may drop the request
  wire logic clr = psel && penable && (pwrite ? ix == 8'h12 : ix == 8'h15 || ix == 8'h19);
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  // ------------------------------
  // Checks
  // ------------------------------
  chk_answer_next: assert property (s_taken |=> s_answer)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  chk_err_map: assert property (psel && penable && pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  chk_err_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_irq_reset: assert property ($rose(presetn) |-> !timer_irq)
    else $error("irq after reset");
  chk_irq_clear: assert property ($fell(timer_irq) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("irq dropped without clearing access");
endmodule // frt_monitor
`default_nettype wire

// >>> sim/cap_src.sv
// Capture source model: pin and comparator flag lines
`timescale 1ns/1ps
`default_nettype none
module cap_src (
  // Clock
  input  wire logic pclk,
  // Bench commands
  input  wire logic use_cmp,
  input  wire logic sel_lvl,
  input  wire logic oth_lvl,
  // Lines to the timer
  output logic      capture_pin,
  output logic      comparator_two_flag
);
  // Lines move just after an edge, like logic-driven sources
  always_ff @(posedge pclk) begin
    capture_pin         <= use_cmp ? oth_lvl : sel_lvl;
    comparator_two_flag <= use_cmp ? sel_lvl : oth_lvl;
  end
endmodule // cap_src
`default_nettype wire

// >>> sim/tb.sv
// Testbench for the free-running timer with capture
`timescale 1ns/1ps
`default_nettype none
module tb;
  import frt_pkg::*;
  // ------------------------------
  // Signals and tasks
  // ------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        capture_pin, comparator_two_flag, use_cmp, sel_lvl, oth_lvl, er, es, s;
  logic [7:0]  a0, a1, ch, cl;
  int          miscompares, checks, cyc;
  localparam logic [7:0] RO [2] = '{IDX_COUNT_HIGH, IDX_ALT_COUNT_HIGH};

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until pready is sampled, then releases
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'h0, ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 8'h00);
    chk(nm, e, rd);
  endtask
  // Irq is registered behind the flags: look one edge later
  task automatic irq_is(input logic e);
    @(posedge pclk);
    chk("timer_irq", e, timer_irq);
  endtask
  // Edge detection takes 3 cycles plus one in the source model
  task automatic gap;
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic [7:0] ctl(input logic e);
    return 8'h80 | (8'(e) << CTL_EDGE_SELECT);
  endfunction
  function automatic logic in_win(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] v);
    logic [7:0] d;
    d = v - lo;
    return d >= 8'h01 && d <= 8'(hi - lo + 8'h01);
  endfunction

  free_running_timer_capture #(.STARTUP_DELAY(4)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .capture_pin, .comparator_two_flag, .timer_irq);
  cap_src src (.pclk, .use_cmp, .sel_lvl, .oth_lvl, .capture_pin, .comparator_two_flag);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    {presetn, psel, penable, pwrite, use_cmp, sel_lvl, oth_lvl} = 7'h0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    pstrb  = 4'hF;
    void'($urandom(54476));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc("count_high", IDX_COUNT_HIGH, 32'hFF);
    apb(1'b0, IDX_COUNT_LOW, 8'h00);
    chk("count_low", 32'h1, rd >= 32'hFC);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h20);
    repeat (24) @(posedge pclk);
    chk("ovf_irq", 32'h1, timer_irq);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    irq_is(1'b0);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h20);
    irq_is(1'b1);
    apb(1'b0, IDX_TIMER_STATUS, 8'h00);
    apb(1'b0, IDX_ALT_COUNT_LOW, 8'h00);
    apb(1'b0, IDX_TIMER_STATUS, 8'h00);
    chk("ovf_kept", 32'h1, rd[STS_OVERFLOW_FLAG]);
    apb(1'b0, IDX_COUNT_LOW, 8'h00);
    irq_is(1'b0);
    apb(1'b0, IDX_COUNT_HIGH, 8'h00);
    apb(1'b0, IDX_ALT_COUNT_LOW, 8'h00);
    a0 = rd[7:0];
    repeat (4) apb(1'b0, IDX_COUNT_HIGH, 8'h00);
    apb(1'b0, IDX_ALT_COUNT_LOW, 8'h00);
    a1 = rd[7:0];
    apb(1'b0, IDX_COUNT_LOW, 8'h00);
    chk("frozen_low", 8'(a0 - 8'h01), rd);
    chk("count_rate", 32'h5, 8'(a1 - a0));
    apb(1'b0, IDX_ALT_COUNT_HIGH, 8'h00);
    apb(1'b0, IDX_COUNT_LOW, 8'h00);
    a0 = rd[7:0];
    apb(1'b0, IDX_ALT_COUNT_LOW, 8'h00);
    chk("alt_frozen", 8'(a0 - 8'h01), rd);
    $display("test startup done");
    for (int i = 0; i < 4; i++) begin
      s  = (i < 2) ? 1'b0 : (i == 2) ? 1'b1 : 1'($urandom_range(1));
      es = (i == 0 || s) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom_range(1));
      use_cmp <= s;
      apb(1'b1, IDX_ANALOG_CONTROL, {7'h0, s});
      apb(1'b1, IDX_TIMER_CONTROL, ctl(es));
      sel_lvl <= es;
      oth_lvl <= ~es;
      gap();
      apb(1'b0, IDX_TIMER_STATUS, 8'h00);
      apb(1'b0, IDX_CAPTURE_LOW, 8'h00);
      sel_lvl <= ~es;
      oth_lvl <= es;
      gap();
      apb(1'b0, IDX_TIMER_STATUS, 8'h00);
      chk("wrong_edge", 32'h0, rd[STS_CAPTURE_FLAG]);
      apb(1'b0, IDX_ALT_COUNT_LOW, 8'h00);
      a0 = rd[7:0];
      sel_lvl <= es;
      gap();
      apb(1'b0, IDX_ALT_COUNT_LOW, 8'h00);
      a1 = rd[7:0];
      apb(1'b0, IDX_TIMER_STATUS, 8'h00);
      chk("cap_flag", 32'h1, rd[STS_CAPTURE_FLAG]);
      irq_is(1'b1);
      apb(1'b0, IDX_CAPTURE_HIGH, 8'h00);
      apb(1'b0, IDX_CAPTURE_LOW, 8'h00);
      cl = rd[7:0];
      chk("cap_value", 32'h1, in_win(a0, a1, cl));
      apb(1'b0, IDX_CAPTURE_HIGH, 8'h00);
      sel_lvl <= ~es;
      gap();
      sel_lvl <= es;
      gap();
      rc("cap_blocked", IDX_CAPTURE_LOW, {24'h0, cl});
      apb(1'b0, IDX_TIMER_STATUS, 8'h00);
      apb(1'b0, IDX_CAPTURE_LOW, 8'h00);
      apb(1'b0, IDX_TIMER_STATUS, 8'h00);
      chk("cap_clear", 32'h0, rd[STS_CAPTURE_FLAG]);
    end
    $display("test capture done");
    apb(1'b0, IDX_CAPTURE_HIGH, 8'h00);
    ch = rd[7:0];
    apb(1'b0, IDX_CAPTURE_LOW, 8'h00);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Count views first: the high byte leaves FF soon after startup
    foreach (RO[k]) begin
      apb(1'b1, RO[k], 8'h00);
      chk("ro_err", 32'h0, er);
      rc("ro_value", RO[k], 32'hFF);
    end
    rc("ctl_reset", IDX_TIMER_CONTROL, {30'h0, es, 1'b0});
    rc("cap_high_kept", IDX_CAPTURE_HIGH, {24'h0, ch});
    rc("cap_low_kept", IDX_CAPTURE_LOW, {24'h0, cl});
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped_err", 32'h1, er);
    chk("unmapped_data", 32'h0, rd);
    $display("test reset done");
    test_done();
  end
endmodule // tb
bind free_running_timer_capture frt_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .timer_irq);
`default_nettype wire
